/* rtl/operating_mode_sequencer.sv */
// Operating-mode sequencer: boot, standby, deep-off, wake, sleep, trigger-wait
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R01 - Going from measuring back to standby keeps every register unchanged.
// R02 - Going from standby into measuring clears a chosen subset of registers.
// R03 - Leaving deep-off loads default values into every setting.
// R04 - Entering deep-off discards state, samples and all host settings.
// R05 - Wake and sleep each use their own power mode and rate settings.
// R06 - Flexible mode enables separately for wake and sleep with idle and decimation.
// R07 - Strap low: after low-strap boot wait, enter standby and await bus commands.
// R08 - Strap high: boot done with motion high enters wake and sets run bit.
// R09 - Strap low: deep-off request in standby enters deep-off; only wake pin exits.
// R10 - Strap high: motion low for debounce time forces and holds deep-off.
// R11 - Strap high: deep-off request still works but wake pin cannot wake.
// R12 - Strap low: host toggles wake pin to restart boot from deep-off.
// R13 - Strap high: motion line high leaves deep-off and starts boot.
// R14 - Strap low: pin2 select 1 enters trigger-wait, 0 returns to standby.
// R15 - Strap high: trigger-wait can never be entered or left.
// R16 - Trigger rising edge in trigger-wait starts one conversion and enters wake.
// R17 - After a triggered measurement completes, return to trigger-wait.
// R18 - Strap low: run bit 1 moves standby to wake, 0 moves back.
// R19 - Strap high: motion low for debounce time clears run; host may clear too.
// R20 - Strap high: host setting run bit in standby resumes motion detection.
// R21 - Countdown at least 1 expiring without enabled event moves wake to sleep.
// R22 - Any enabled event source in sleep returns the device to wake.
// R23 - Boot completion sets boot-done flag and pulses the boot output.
// R24 - Strap low: wake pin edge in either direction exits deep-off.
// R25 - Modes are distinct enumerated states with exactly one active.
module operating_mode_sequencer #(
  parameter int unsigned BOOT_WAIT_LOW_CYC = opmode_pkg::BOOT_WAIT_LOW_CYC,
  parameter int unsigned BOOT_WAIT_HIGH_CYC = opmode_pkg::BOOT_WAIT_HIGH_CYC,
  parameter int unsigned MOTION_LOW_DEBOUNCE_CYC = opmode_pkg::MOTION_LOW_DEBOUNCE_CYC,
  parameter int unsigned SLEEP_TICK_CYC = opmode_pkg::SLEEP_TICK_CYC
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic BOOT_STRAP_SELECT_IN,
  input wire logic WAKE_PIN_IN,
  input wire logic MOTION_LINE_IN,
  input wire logic TRIGGER_IN,
  input wire logic MEAS_DONE_IN,
  input wire logic [7:0] AWS_EVENT_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  output logic [7:0] RD_DATA_OUT,
  output logic [2:0] MODE_OUT,
  output logic BOOT_PULSE_OUT,
  output logic CONV_START_OUT,
  output logic MEASURING_OUT,
  output logic HPM_OUT,
  output logic FPM_OUT,
  output logic [3:0] ODR_OUT,
  output logic [7:0] FPM_IDLE_OUT,
  output logic [7:0] FPM_DECIM_OUT
);

  localparam int unsigned CW = opmode_pkg::CNT_W;
  localparam logic [CW-1:0] BOOT_LOW_LAST = CW'(BOOT_WAIT_LOW_CYC - 1);
  localparam logic [CW-1:0] BOOT_HIGH_LAST = CW'(BOOT_WAIT_HIGH_CYC - 1);
  localparam logic [CW-1:0] MOT_LOW_LAST = CW'(MOTION_LOW_DEBOUNCE_CYC - 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(SLEEP_TICK_CYC - 1);

  typedef struct packed {
    opmode_pkg::mode_e mode;
    logic strap;
    logic [7:0] ctrl;
    logic [7:0] wake_cfg;
    logic [7:0] sleep_cfg;
    logic [7:0] fpm_idle;
    logic [7:0] fpm_decim;
    logic [7:0] sleep_count;
    logic [7:0] aws_en;
    logic [7:0] evt_latch;
    logic boot_done;
    logic trig_meas;
    logic [CW-1:0] cnt;
    logic [CW-1:0] tick_cnt;
    logic [7:0] sleep_cnt;
    logic wake_pin_prev;
    logic trig_prev;
    logic [7:0] rd_data;
    logic boot_pulse;
    logic conv_start;
  } state_s;

  state_s s_q;
  state_s s_d;

  function automatic logic bus_open(input opmode_pkg::mode_e m);
    bus_open = (m == opmode_pkg::MODE_STANDBY) || (m == opmode_pkg::MODE_WAKE) ||
               (m == opmode_pkg::MODE_SLEEP) || (m == opmode_pkg::MODE_TRIG_WAIT);
  endfunction : bus_open

  function automatic logic is_measuring(input opmode_pkg::mode_e m);
    is_measuring = (m == opmode_pkg::MODE_WAKE) || (m == opmode_pkg::MODE_SLEEP);
  endfunction : is_measuring

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic wr_ok;
  logic evt_hit;
  logic motion_low_done;
  logic wake_edge;
  logic trig_rise;

  always_comb begin
    s_d = s_q;
    s_d.boot_pulse = 1'b0;
    s_d.conv_start = 1'b0;
    s_d.rd_data = 8'h00;
    s_d.wake_pin_prev = WAKE_PIN_IN;
    s_d.trig_prev = TRIGGER_IN;
    wr_ok = WR_EN_IN && bus_open(s_q.mode);
    evt_hit = |(AWS_EVENT_IN & s_q.aws_en);
    motion_low_done = s_q.strap && !MOTION_LINE_IN && (s_q.cnt >= MOT_LOW_LAST);
    wake_edge = (WAKE_PIN_IN != s_q.wake_pin_prev);
    trig_rise = TRIGGER_IN && !s_q.trig_prev;

    // Sticky event latch, set wins
    if (bus_open(s_q.mode)) begin
      s_d.evt_latch = s_q.evt_latch | AWS_EVENT_IN;
    end

    // Register reads
    if (RD_EN_IN && bus_open(s_q.mode)) begin
      unique case (ADDR_IN)
        opmode_pkg::CTRL_ADDR: s_d.rd_data = s_q.ctrl;
        opmode_pkg::WAKE_CFG_ADDR: s_d.rd_data = s_q.wake_cfg;
        opmode_pkg::SLEEP_CFG_ADDR: s_d.rd_data = s_q.sleep_cfg;
        opmode_pkg::FPM_IDLE_ADDR: s_d.rd_data = s_q.fpm_idle;
        opmode_pkg::FPM_DECIM_ADDR: s_d.rd_data = s_q.fpm_decim;
        opmode_pkg::SLEEP_COUNT_ADDR: s_d.rd_data = s_q.sleep_count;
        opmode_pkg::AWS_EN_ADDR: s_d.rd_data = s_q.aws_en;
        opmode_pkg::STATUS_ADDR: s_d.rd_data = {s_q.boot_done, s_q.strap, s_q.trig_meas,
                                                2'b00, s_q.mode};
        opmode_pkg::EVT_LATCH_ADDR: s_d.rd_data = s_q.evt_latch;
        default: s_d.rd_data = 8'h00;
      endcase
    end

    // Register writes
    if (wr_ok) begin
      unique case (ADDR_IN)
        opmode_pkg::CTRL_ADDR: begin
          s_d.ctrl = WR_DATA_IN;
          if (s_q.strap) begin
            s_d.ctrl[opmode_pkg::PIN2_SEL_BIT] = 1'b0; // [R15]
          end
        end
        opmode_pkg::WAKE_CFG_ADDR: s_d.wake_cfg = WR_DATA_IN; // [R05]
        opmode_pkg::SLEEP_CFG_ADDR: s_d.sleep_cfg = WR_DATA_IN; // [R05]
        opmode_pkg::FPM_IDLE_ADDR: s_d.fpm_idle = WR_DATA_IN; // [R06]
        opmode_pkg::FPM_DECIM_ADDR: s_d.fpm_decim = WR_DATA_IN; // [R06]
        opmode_pkg::SLEEP_COUNT_ADDR: s_d.sleep_count = WR_DATA_IN;
        opmode_pkg::AWS_EN_ADDR: s_d.aws_en = WR_DATA_IN;
        opmode_pkg::EVT_LATCH_ADDR: s_d.evt_latch = AWS_EVENT_IN; // Clear, set wins
        default: begin
        end
      endcase
    end

    // Mode sequencing
    unique case (s_q.mode)
      opmode_pkg::MODE_OFF: begin
        s_d.mode = opmode_pkg::MODE_BOOT;
        s_d.strap = BOOT_STRAP_SELECT_IN;
        s_d.cnt = '0;
      end
      opmode_pkg::MODE_BOOT: begin
        s_d.cnt = s_q.cnt + CW'(1);
        if (s_q.cnt >= (s_q.strap ? BOOT_HIGH_LAST : BOOT_LOW_LAST)) begin
          s_d.cnt = '0;
          s_d.boot_done = 1'b1; // [R23]
          s_d.boot_pulse = 1'b1; // [R23]
          if (!s_q.strap) begin
            s_d.mode = opmode_pkg::MODE_STANDBY; // [R07]
          end else if (MOTION_LINE_IN) begin
            s_d.mode = opmode_pkg::MODE_WAKE; // [R08]
            s_d.ctrl[opmode_pkg::RUN_BIT] = 1'b1; // [R08]
          end else begin
            s_d.mode = opmode_pkg::MODE_DEEP_OFF;
          end
        end
      end
      opmode_pkg::MODE_DEEP_OFF: begin
        if (s_q.strap ? MOTION_LINE_IN : wake_edge) begin // [R13] [R24] [R09] [R11]
          s_d.mode = opmode_pkg::MODE_BOOT;
          s_d.cnt = '0;
        end
      end
      opmode_pkg::MODE_STANDBY: begin
        if (s_d.ctrl[opmode_pkg::DEEP_OFF_BIT]) begin
          s_d.mode = opmode_pkg::MODE_DEEP_OFF; // [R09] [R11]
        end else if (s_d.ctrl[opmode_pkg::RUN_BIT]) begin
          s_d.mode = opmode_pkg::MODE_WAKE; // [R18] [R20]
          s_d.evt_latch = 8'h00; // [R02]
          s_d.sleep_cnt = 8'h00; // [R02]
          s_d.tick_cnt = '0; // [R02]
        end else if (s_d.ctrl[opmode_pkg::PIN2_SEL_BIT] && !s_q.strap) begin
          s_d.mode = opmode_pkg::MODE_TRIG_WAIT; // [R14]
        end
      end
      opmode_pkg::MODE_TRIG_WAIT: begin
        if (!s_d.ctrl[opmode_pkg::PIN2_SEL_BIT]) begin
          s_d.mode = opmode_pkg::MODE_STANDBY; // [R14]
        end else if (trig_rise) begin
          s_d.mode = opmode_pkg::MODE_WAKE; // [R16]
          s_d.conv_start = 1'b1; // [R16]
          s_d.trig_meas = 1'b1;
        end
      end
      opmode_pkg::MODE_WAKE: begin
        if (s_q.trig_meas) begin
          if (MEAS_DONE_IN) begin
            s_d.mode = opmode_pkg::MODE_TRIG_WAIT; // [R17]
            s_d.trig_meas = 1'b0;
          end
        end else if (!s_d.ctrl[opmode_pkg::RUN_BIT]) begin
          s_d.mode = opmode_pkg::MODE_STANDBY; // [R18] [R19] [R01]
        end else if (s_q.sleep_count != 8'h00) begin
          s_d.tick_cnt = s_q.tick_cnt + CW'(1);
          if (evt_hit) begin
            s_d.tick_cnt = '0; // [R21]
            s_d.sleep_cnt = 8'h00;
          end else if (s_q.tick_cnt >= TICK_LAST) begin
            s_d.tick_cnt = '0;
            s_d.sleep_cnt = s_q.sleep_cnt + 8'h01;
            if (s_q.sleep_cnt + 8'h01 >= s_q.sleep_count) begin
              s_d.mode = opmode_pkg::MODE_SLEEP; // [R21]
              s_d.sleep_cnt = 8'h00;
            end
          end
        end
      end
      opmode_pkg::MODE_SLEEP: begin
        if (!s_d.ctrl[opmode_pkg::RUN_BIT]) begin
          s_d.mode = opmode_pkg::MODE_STANDBY; // [R18] [R01]
        end else if (evt_hit) begin
          s_d.mode = opmode_pkg::MODE_WAKE; // [R22]
          s_d.tick_cnt = '0;
        end
      end
      default: s_d.mode = opmode_pkg::MODE_OFF; // [R25]
    endcase

    // Motion-low debounce with high strap
    if (s_q.strap && bus_open(s_q.mode)) begin
      s_d.cnt = MOTION_LINE_IN ? '0 : s_q.cnt + CW'(1);
      if (motion_low_done) begin
        s_d.ctrl[opmode_pkg::RUN_BIT] = 1'b0; // [R19]
        s_d.mode = opmode_pkg::MODE_DEEP_OFF; // [R10]
      end
    end

    // Deep-off loses all settings, flags and counters but keeps the strap; leaving it reloads defaults
    if ((s_d.mode == opmode_pkg::MODE_DEEP_OFF && s_q.mode != opmode_pkg::MODE_DEEP_OFF) ||
        (s_d.mode == opmode_pkg::MODE_BOOT && s_q.mode == opmode_pkg::MODE_DEEP_OFF)) begin
      s_d.ctrl = opmode_pkg::CTRL_RST; // [R03] [R04]
      s_d.wake_cfg = opmode_pkg::WAKE_CFG_RST;
      s_d.sleep_cfg = opmode_pkg::SLEEP_CFG_RST;
      s_d.fpm_idle = opmode_pkg::FPM_IDLE_RST;
      s_d.fpm_decim = opmode_pkg::FPM_DECIM_RST;
      s_d.sleep_count = opmode_pkg::SLEEP_COUNT_RST;
      s_d.aws_en = opmode_pkg::AWS_EN_RST;
      s_d.evt_latch = 8'h00;
      s_d.boot_done = 1'b0;
      s_d.trig_meas = 1'b0;
      s_d.cnt = '0;
      s_d.tick_cnt = '0;
      s_d.sleep_cnt = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      s_q <= '0;
      s_q.mode <= opmode_pkg::MODE_OFF;
      s_q.ctrl <= opmode_pkg::CTRL_RST;
      s_q.wake_cfg <= opmode_pkg::WAKE_CFG_RST;
      s_q.sleep_cfg <= opmode_pkg::SLEEP_CFG_RST;
      s_q.fpm_idle <= opmode_pkg::FPM_IDLE_RST;
      s_q.fpm_decim <= opmode_pkg::FPM_DECIM_RST;
      s_q.sleep_count <= opmode_pkg::SLEEP_COUNT_RST;
      s_q.aws_en <= opmode_pkg::AWS_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic [7:0] act_cfg;
  logic act_fpm;

  always_comb begin
    act_cfg = (s_q.mode == opmode_pkg::MODE_SLEEP) ? s_q.sleep_cfg : s_q.wake_cfg; // [R05]
    act_fpm = act_cfg[opmode_pkg::FPM_BIT]; // [R06]
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      HPM_OUT <= 1'b0;
      FPM_OUT <= 1'b0;
      ODR_OUT <= 4'h0;
      FPM_IDLE_OUT <= 8'h00;
      FPM_DECIM_OUT <= 8'h00;
      MEASURING_OUT <= 1'b0;
    end else begin
      HPM_OUT <= act_cfg[opmode_pkg::HPM_BIT];
      FPM_OUT <= act_fpm;
      ODR_OUT <= act_cfg[opmode_pkg::ODR_LSB +: 4];
      FPM_IDLE_OUT <= act_fpm ? s_q.fpm_idle : 8'h00; // [R06]
      FPM_DECIM_OUT <= act_fpm ? s_q.fpm_decim : 8'h00; // [R06]
      MEASURING_OUT <= is_measuring(s_d.mode);
    end
  end

  always_comb begin
    RD_DATA_OUT = s_q.rd_data;
    MODE_OUT = s_q.mode;
    BOOT_PULSE_OUT = s_q.boot_pulse;
    CONV_START_OUT = s_q.conv_start;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_deep_req;
    s_q.mode == opmode_pkg::MODE_STANDBY && WR_EN_IN && ADDR_IN == opmode_pkg::CTRL_ADDR &&
      WR_DATA_IN[opmode_pkg::DEEP_OFF_BIT] && !(s_q.strap && !MOTION_LINE_IN);
  endsequence

  property p_deep_req;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      s_deep_req |=> s_q.mode == opmode_pkg::MODE_DEEP_OFF && s_q.ctrl == opmode_pkg::CTRL_RST;
  endproperty
  a_deep_req: assert property (p_deep_req) else $error("Deep-off request not honoured"); // [R09]

  property p_wake_pin_ignored;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (s_q.mode == opmode_pkg::MODE_DEEP_OFF && s_q.strap && !MOTION_LINE_IN)
      |=> s_q.mode == opmode_pkg::MODE_DEEP_OFF;
  endproperty
  a_wake_pin_ignored: assert property (p_wake_pin_ignored) else $error("Left deep-off"); // [R11]

  property p_wake_edge_exit;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (s_q.mode == opmode_pkg::MODE_DEEP_OFF && !s_q.strap && WAKE_PIN_IN != s_q.wake_pin_prev)
      |=> s_q.mode == opmode_pkg::MODE_BOOT ##1 s_q.cnt == 24'h000001;
  endproperty
  a_wake_edge_exit: assert property (p_wake_edge_exit) else $error("Wake edge lost"); // [R24]

  property p_motion_boot;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (s_q.mode == opmode_pkg::MODE_DEEP_OFF && s_q.strap && MOTION_LINE_IN)
      |=> s_q.mode == opmode_pkg::MODE_BOOT && s_q.wake_cfg == opmode_pkg::WAKE_CFG_RST;
  endproperty
  a_motion_boot: assert property (p_motion_boot) else $error("Motion did not boot"); // [R13]

  property p_no_trig_high;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      s_q.strap |-> s_q.mode != opmode_pkg::MODE_TRIG_WAIT && !s_q.ctrl[opmode_pkg::PIN2_SEL_BIT];
  endproperty
  a_no_trig_high: assert property (p_no_trig_high) else $error("Trigger-wait with strap high"); // [R15]

  sequence s_trig_fire;
    s_q.mode == opmode_pkg::MODE_TRIG_WAIT && s_q.ctrl[opmode_pkg::PIN2_SEL_BIT] &&
      !WR_EN_IN && TRIGGER_IN && !s_q.trig_prev;
  endsequence

  property p_trig_fire;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      s_trig_fire |=> s_q.mode == opmode_pkg::MODE_WAKE && s_q.conv_start ##1 !s_q.conv_start;
  endproperty
  a_trig_fire: assert property (p_trig_fire) else $error("Trigger did not start conversion"); // [R16]

  property p_trig_return;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (s_q.mode == opmode_pkg::MODE_WAKE && s_q.trig_meas && MEAS_DONE_IN && !s_q.strap)
      |=> s_q.mode == opmode_pkg::MODE_TRIG_WAIT && !s_q.trig_meas;
  endproperty
  a_trig_return: assert property (p_trig_return) else $error("No return to trigger-wait"); // [R17]

  property p_run_start;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (s_q.mode == opmode_pkg::MODE_STANDBY && WR_EN_IN && ADDR_IN == opmode_pkg::CTRL_ADDR &&
       WR_DATA_IN == 8'h01 && (!s_q.strap || MOTION_LINE_IN))
      |=> s_q.mode == opmode_pkg::MODE_WAKE && s_q.evt_latch == 8'h00;
  endproperty
  a_run_start: assert property (p_run_start) else $error("Run bit did not start wake"); // [R18]

  property p_keep_regs;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (is_measuring($past(s_q.mode)) && s_q.mode == opmode_pkg::MODE_STANDBY)
      |-> $stable(s_q.wake_cfg) && $stable(s_q.sleep_cfg) && $stable(s_q.aws_en);
  endproperty
  a_keep_regs: assert property (p_keep_regs) else $error("Settings changed leaving wake"); // [R01]

  property p_sleep_exit;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (s_q.mode == opmode_pkg::MODE_SLEEP && s_q.ctrl[opmode_pkg::RUN_BIT] && !WR_EN_IN &&
       (|(AWS_EVENT_IN & s_q.aws_en)) && !(s_q.strap && !MOTION_LINE_IN))
      |=> s_q.mode == opmode_pkg::MODE_WAKE;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("Sleep did not wake"); // [R22]

  property p_boot_done;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      $rose(s_q.boot_done) |-> s_q.boot_pulse && $past(s_q.mode) == opmode_pkg::MODE_BOOT;
  endproperty
  a_boot_done: assert property (p_boot_done) else $error("Boot flag without pulse"); // [R23]

endmodule : operating_mode_sequencer

`default_nettype wire

/* rtl/opmode_pkg.sv */
// Constants, register map and mode encoding of the operating-mode sequencer
package opmode_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned BOOT_WAIT_LOW_US = 1000;
  localparam int unsigned BOOT_WAIT_HIGH_US = 1000;
  localparam int unsigned MOTION_LOW_DEBOUNCE_US = 1000;
  localparam int unsigned SLEEP_TICK_US = 1000;
  localparam int unsigned BOOT_WAIT_LOW_CYC = BOOT_WAIT_LOW_US * CYC_PER_US;
  localparam int unsigned BOOT_WAIT_HIGH_CYC = BOOT_WAIT_HIGH_US * CYC_PER_US;
  localparam int unsigned MOTION_LOW_DEBOUNCE_CYC = MOTION_LOW_DEBOUNCE_US * CYC_PER_US;
  localparam int unsigned SLEEP_TICK_CYC = SLEEP_TICK_US * CYC_PER_US;
  localparam int unsigned CNT_W = 24;

  // Register offsets
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] WAKE_CFG_ADDR = 4'h1;
  localparam logic [3:0] SLEEP_CFG_ADDR = 4'h2;
  localparam logic [3:0] FPM_IDLE_ADDR = 4'h3;
  localparam logic [3:0] FPM_DECIM_ADDR = 4'h4;
  localparam logic [3:0] SLEEP_COUNT_ADDR = 4'h5;
  localparam logic [3:0] AWS_EN_ADDR = 4'h6;
  localparam logic [3:0] STATUS_ADDR = 4'h7;
  localparam logic [3:0] EVT_LATCH_ADDR = 4'h8;

  // Field positions
  localparam int unsigned RUN_BIT = 0;
  localparam int unsigned DEEP_OFF_BIT = 1;
  localparam int unsigned PIN2_SEL_BIT = 2;
  localparam int unsigned HPM_BIT = 0;
  localparam int unsigned FPM_BIT = 1;
  localparam int unsigned ODR_LSB = 4;
  localparam int unsigned STAT_BOOT_DONE_BIT = 7;
  localparam int unsigned STAT_STRAP_BIT = 6;
  localparam int unsigned STAT_TRIG_BIT = 5;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] WAKE_CFG_RST = 8'h01;
  localparam logic [7:0] SLEEP_CFG_RST = 8'h00;
  localparam logic [7:0] FPM_IDLE_RST = 8'h00;
  localparam logic [7:0] FPM_DECIM_RST = 8'h00;
  localparam logic [7:0] SLEEP_COUNT_RST = 8'h00;
  localparam logic [7:0] AWS_EN_RST = 8'h00;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_BOOT,
    MODE_STANDBY,
    MODE_DEEP_OFF,
    MODE_WAKE,
    MODE_SLEEP,
    MODE_TRIG_WAIT
  } mode_e;

endpackage : opmode_pkg

/* verif/host_pins_model.sv */
// Host side pin model: wake pin, motion line, trigger, measurement done, events
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
  input wire logic clk_in,
  output logic wake_out,
  output logic motion_out,
  output logic trigger_out,
  output logic done_out,
  output logic [7:0] event_out
);
  initial begin
    wake_out = 1'b1;
    motion_out = 1'b1;
    trigger_out = 1'b0;
    done_out = 1'b0;
    event_out = 8'h00;
  end
  // Wake pin edge; the bench issues it only in deep-off
  task automatic toggle_wake();
    @(posedge clk_in);
    wake_out <= ~wake_out;
  endtask : toggle_wake
  // Motion line level, held low until deep-off is seen
  task automatic set_motion(input logic v);
    @(posedge clk_in);
    motion_out <= v;
  endtask : set_motion
  // Trigger level; a rise acts in trigger-wait
  task automatic set_trigger(input logic v);
    @(posedge clk_in);
    trigger_out <= v;
  endtask : set_trigger
  // One-cycle measurement finished
  task automatic pulse_done();
    @(posedge clk_in);
    done_out <= 1'b1;
    @(posedge clk_in);
    done_out <= 1'b0;
  endtask : pulse_done
  // One-cycle wake/sleep event
  task automatic pulse_event(input logic [7:0] m);
    @(posedge clk_in);
    event_out <= m;
    @(posedge clk_in);
    event_out <= 8'h00;
  endtask : pulse_event
endmodule : host_pins_model
`default_nettype wire

/* verif/operating_mode_sequencer_test.sv */
// Self-checking testbench of the operating-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module operating_mode_sequencer_test;
  logic clk, rst, strap, wake, motion, trig, done, we, re;
  logic [7:0] evt, wdata, rdata, idle, decim;
  logic [3:0] addr, odr;
  logic [2:0] mode;
  logic boot_pulse, conv_start, measuring, high_performance_mode, flexible_performance_mode;
  int n_mismatch = 0;
  int comparisons = 0;
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    strap = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    we = 1'b0;
    re = 1'b0;
  end
  always #10 clk = ~clk;
  host_pins_model i_host (.clk_in(clk), .wake_out(wake), .motion_out(motion),
    .trigger_out(trig), .done_out(done), .event_out(evt));
  operating_mode_sequencer #(.BOOT_WAIT_LOW_CYC(8), .BOOT_WAIT_HIGH_CYC(8),
    .MOTION_LOW_DEBOUNCE_CYC(8), .SLEEP_TICK_CYC(8)) i_dut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .BOOT_STRAP_SELECT_IN(strap), .WAKE_PIN_IN(wake),
    .MOTION_LINE_IN(motion), .TRIGGER_IN(trig), .MEAS_DONE_IN(done), .AWS_EVENT_IN(evt),
    .ADDR_IN(addr), .WR_DATA_IN(wdata), .WR_EN_IN(we), .RD_EN_IN(re), .RD_DATA_OUT(rdata),
    .MODE_OUT(mode), .BOOT_PULSE_OUT(boot_pulse), .CONV_START_OUT(conv_start),
    .MEASURING_OUT(measuring), .HPM_OUT(high_performance_mode), .FPM_OUT(flexible_performance_mode), .ODR_OUT(odr),
    .FPM_IDLE_OUT(idle), .FPM_DECIM_OUT(decim));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check8
  task automatic power_up(input logic s);
    @(posedge clk);
    strap <= s;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask : power_up
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    check8(rdata, exp);
  endtask : rd
  task automatic wait_mode(input logic [2:0] exp, input int max);
    int i;
    i = 0;
    while (mode !== exp && i < max) begin
      @(posedge clk);
      #1;
      i++;
    end
    check8({5'h00, mode}, {5'h00, exp});
  endtask : wait_mode
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200_000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    power_up(1'b0);
    wait_mode(opmode_pkg::MODE_STANDBY, 20);
    check8({7'h00, boot_pulse}, 8'h01);
    rd(opmode_pkg::STATUS_ADDR, 8'h82);
    rd(opmode_pkg::WAKE_CFG_ADDR, 8'h01);
    rd(4'h9, 8'h00);
    wr(opmode_pkg::FPM_IDLE_ADDR, 8'h05);
    wr(opmode_pkg::FPM_DECIM_ADDR, 8'h87);
    wr(opmode_pkg::WAKE_CFG_ADDR, 8'h33);
    wr(opmode_pkg::CTRL_ADDR, 8'h01);
    wait_mode(opmode_pkg::MODE_WAKE, 4);
    repeat (2) @(posedge clk);
    #1;
    check8({odr, 2'b00, flexible_performance_mode, high_performance_mode}, 8'h33);
    check8(idle, 8'h05);
    check8(decim, 8'h87);
    check8({7'h00, measuring}, 8'h01);
    wr(opmode_pkg::CTRL_ADDR, 8'h00);
    wait_mode(opmode_pkg::MODE_STANDBY, 4);
    rd(opmode_pkg::WAKE_CFG_ADDR, 8'h33);
    wr(opmode_pkg::CTRL_ADDR, 8'h04);
    wait_mode(opmode_pkg::MODE_TRIG_WAIT, 4);
    i_host.set_trigger(1'b1);
    wait_mode(opmode_pkg::MODE_WAKE, 4);
    check8({7'h00, conv_start}, 8'h01);
    i_host.pulse_done();
    wait_mode(opmode_pkg::MODE_TRIG_WAIT, 4);
    i_host.set_trigger(1'b0);
    wr(opmode_pkg::CTRL_ADDR, 8'h00);
    wait_mode(opmode_pkg::MODE_STANDBY, 4);
    wr(opmode_pkg::SLEEP_CFG_ADDR, 8'h50);
    wr(opmode_pkg::SLEEP_COUNT_ADDR, 8'h01);
    wr(opmode_pkg::AWS_EN_ADDR, 8'h01);
    wr(opmode_pkg::CTRL_ADDR, 8'h01);
    wait_mode(opmode_pkg::MODE_WAKE, 4);
    wait_mode(opmode_pkg::MODE_SLEEP, 40);
    repeat (2) @(posedge clk);
    #1;
    check8({odr, 2'b00, flexible_performance_mode, high_performance_mode}, 8'h50);
    check8(idle, 8'h00);
    check8(decim, 8'h00);
    i_host.pulse_event(8'hfe);
    @(posedge clk);
    #1;
    wait_mode(opmode_pkg::MODE_SLEEP, 0);
    i_host.pulse_event(8'h01);
    wait_mode(opmode_pkg::MODE_WAKE, 4);
    wr(opmode_pkg::CTRL_ADDR, 8'h00);
    wait_mode(opmode_pkg::MODE_STANDBY, 4);
    rd(opmode_pkg::EVT_LATCH_ADDR, 8'hff);
    wr(opmode_pkg::CTRL_ADDR, 8'h01);
    rd(opmode_pkg::EVT_LATCH_ADDR, 8'h00);
    wr(opmode_pkg::CTRL_ADDR, 8'h00);
    wait_mode(opmode_pkg::MODE_STANDBY, 4);
    wr(opmode_pkg::CTRL_ADDR, 8'h02);
    wait_mode(opmode_pkg::MODE_DEEP_OFF, 4);
    rd(opmode_pkg::WAKE_CFG_ADDR, 8'h00);
    i_host.toggle_wake();
    wait_mode(opmode_pkg::MODE_BOOT, 4);
    wait_mode(opmode_pkg::MODE_STANDBY, 20);
    rd(opmode_pkg::WAKE_CFG_ADDR, 8'h01);
    rd(opmode_pkg::FPM_IDLE_ADDR, 8'h00);
    rd(opmode_pkg::SLEEP_CFG_ADDR, 8'h00);
    power_up(1'b1);
    wait_mode(opmode_pkg::MODE_WAKE, 30);
    rd(opmode_pkg::CTRL_ADDR, 8'h01);
    wr(opmode_pkg::CTRL_ADDR, 8'h04);
    wait_mode(opmode_pkg::MODE_STANDBY, 4);
    rd(opmode_pkg::CTRL_ADDR, 8'h00);
    wr(opmode_pkg::CTRL_ADDR, 8'h01);
    wait_mode(opmode_pkg::MODE_WAKE, 4);
    i_host.set_motion(1'b0);
    wait_mode(opmode_pkg::MODE_DEEP_OFF, 30);
    i_host.toggle_wake();
    repeat (10) @(posedge clk);
    wait_mode(opmode_pkg::MODE_DEEP_OFF, 0);
    i_host.set_motion(1'b1);
    wait_mode(opmode_pkg::MODE_BOOT, 4);
    wait_mode(opmode_pkg::MODE_WAKE, 30);
    print_verdict();
  end
endmodule : operating_mode_sequencer_test
`default_nettype wire
